// *** common/cac_regs.svh ***
// register offsets, field positions, reset values and timing counts of the counter array
`ifndef CAC_REGS_SVH
`define CAC_REGS_SVH

// register offsets on the special function register bus
`define CAC_ADDR_CLR_CTL   8'hce
`define CAC_ADDR_CTL       8'hd8
`define CAC_ADDR_MODE      8'hd9
`define CAC_ADDR_PWM_CFG   8'hdf
`define CAC_ADDR_CNT_LO    8'hf9
`define CAC_ADDR_CNT_HI    8'hfa
`define CAC_ADDR_CPM0      8'hda
`define CAC_ADDR_CPL0      8'hfb
`define CAC_ADDR_CPH0      8'hfc
`define CAC_ADDR_CPM1      8'hdb
`define CAC_ADDR_CPL1      8'he9
`define CAC_ADDR_CPH1      8'hea
`define CAC_ADDR_CPM2      8'hdc
`define CAC_ADDR_CPL2      8'heb
`define CAC_ADDR_CPH2      8'hec

// control register fields
`define CAC_CTL_OVF        7
`define CAC_CTL_RUN        6
`define CAC_CTL_FLAGS_MASK 8'hc7

// comparator clear control fields
`define CAC_CLR_POL        7

// counter mode register fields
`define CAC_MD_OVF_IE      0
`define CAC_MD_CLKSEL_LO   1
`define CAC_MD_CLKSEL_HI   3

// channel mode register fields
`define CAC_CPM_PWM16      7
`define CAC_CPM_ECOM       6
`define CAC_CPM_CAPP       5
`define CAC_CPM_CAPN       4
`define CAC_CPM_MAT        3
`define CAC_CPM_TOG        2
`define CAC_CPM_PWM        1
`define CAC_CPM_ECCF       0

// reset values
`define CAC_RST_BYTE       8'h00

// clock source dividers
`define CAC_DIV_SLOW       12
`define CAC_DIV_FAST       4

`endif

// *** common/cac_pkg.sv ***
// types shared by the counter array design
package cac_pkg;

	typedef enum logic [2:0] {
		CAC_MODE_OFF,
		CAC_MODE_CAPTURE,
		CAC_MODE_SW_TIMER,
		CAC_MODE_HS_OUT,
		CAC_MODE_FREQ_OUT,
		CAC_MODE_PWM_SHARED,
		CAC_MODE_PWM16
	} cac_mode_t;

	typedef enum logic [2:0] {
		CAC_CLK_DIV12,
		CAC_CLK_DIV4,
		CAC_CLK_TIMER_OVF,
		CAC_CLK_EXT_EDGE,
		CAC_CLK_SYS,
		CAC_CLK_EXT_OSC
	} cac_clk_sel_t;

endpackage : cac_pkg

// *** core/cac_counter_array.sv ***
// counter array with three capture/compare channels behind the sfr bus
//
// Notes on behaviour
// - high-speed output toggles channel pin when counter equals 16-bit compare value.
// - high-speed output match sets the channel match flag.
// - interrupt request raised when a set match flag has its interrupt enabled.
// - hardware never clears a match flag; software must clear it.
// - toggle, match-flag and compare enables together select high-speed output mode.
// - compare enable low holds the pin and skips the next toggle.
// - low compare byte write clears compare enable; high byte write sets it.
// - frequency mode high byte is toggle period; zero means 256 clocks.
// - frequency mode matches low bytes, toggles, adds high byte to low byte.
// - compare, toggle and pwm enables together select frequency output mode.
// - frequency mode with match-flag enable flags only on full 16-bit equality.
// - one common 8 to 11 bit cycle length for all shared-length pwm channels.
// - other channels configure independently for capture, timer, outputs or 16-bit pwm.
// - wrap from ffff to 0000 sets overflow flag, may interrupt; software clears.
// - counter stops while run bit 6 is zero and counts while one.
// - control bits 5:3 read as zero and ignore writes.
// - channel 0 to 2 flags set on a capture, or on a full 16-bit match with match and compare enables set outside capture and pwm modes, of that channel.
// - clear polarity bit 7 picks falling or rising comparator edge for clearing.
// - clear-control bits 0 to 2 enable comparator clearing per channel.
`include "cac_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cac_counter_array #(
	parameter int NCH      = 3,
	parameter int DIV_SLOW = `CAC_DIV_SLOW,
	parameter int DIV_FAST = `CAC_DIV_FAST
) (
	// clock and reset
	input  wire  logic           i_ref_clk,
	input  wire  logic           i_rst,
	// sfr bus
	input  wire  logic [7:0]     i_sfr_addr,
	input  wire  logic           i_sfr_wr,
	input  wire  logic [7:0]     i_sfr_wdata,
	output var   logic [7:0]     o_sfr_rdata,
	// external clock sources, one-cycle pulses
	input  wire  logic           i_timer_ovf,
	input  wire  logic           i_ext_edge,
	input  wire  logic           i_ext_osc_tick,
	// channel pins and comparator
	input  wire  logic [NCH-1:0] i_capture_in,
	input  wire  logic           i_cmp_result,
	output var   logic [NCH-1:0] o_channel_output_pin,
	output var   logic           o_irq
);

	function automatic cac_pkg::cac_mode_t cac_decode(input logic [7:0] m);
		cac_pkg::cac_mode_t md;
		md = cac_pkg::CAC_MODE_OFF;
		if (m[`CAC_CPM_CAPP] || m[`CAC_CPM_CAPN]) begin
			md = cac_pkg::CAC_MODE_CAPTURE;
			// compare, toggle and pwm select frequency
		end else if (m[`CAC_CPM_ECOM] && m[`CAC_CPM_PWM] && m[`CAC_CPM_TOG]) begin
			md = cac_pkg::CAC_MODE_FREQ_OUT;
		end else if (m[`CAC_CPM_ECOM] && m[`CAC_CPM_PWM] && m[`CAC_CPM_PWM16]) begin
			md = cac_pkg::CAC_MODE_PWM16;
		end else if (m[`CAC_CPM_ECOM] && m[`CAC_CPM_PWM]) begin
			md = cac_pkg::CAC_MODE_PWM_SHARED;
			// compare, match and toggle select high-speed
		end else if (m[`CAC_CPM_ECOM] && m[`CAC_CPM_MAT] && m[`CAC_CPM_TOG]) begin
			md = cac_pkg::CAC_MODE_HS_OUT;
		end else if (m[`CAC_CPM_MAT]) begin
			md = cac_pkg::CAC_MODE_SW_TIMER;
		end
		return md;
	endfunction : cac_decode

	function automatic logic cac_hit(input logic [7:0] a, input logic [7:0] b);
		return i_sfr_wr && (i_sfr_addr == a) && (i_sfr_addr == b);
	endfunction : cac_hit

	logic [7:0]     ctl_run_r;
	logic           ovf_flag_r;
	logic [NCH-1:0] ch_flag_r;
	logic [7:0]     clr_ctl_r;
	logic [7:0]     mode_r;
	logic [1:0]     pwm_len_r;
	logic [15:0]    cnt_r;
	logic [7:0]     cpm_r [NCH];
	logic [7:0]     cpl_r [NCH];
	logic [7:0]     cph_r [NCH];
	logic [NCH-1:0] cap_prev_r;
	logic           cmp_prev_r;
	logic [3:0]     div_slow_r;
	logic [1:0]     div_fast_r;

	logic           tick;
	logic           src_tick;
	logic           run;
	logic           clr_evt;
	logic [10:0]    pwm_mask;
	logic [NCH-1:0] ch_evt;
	logic [NCH-1:0] tog_evt;
	logic [NCH-1:0] cap_evt;
	logic [NCH-1:0] pwm_lvl;
	logic [NCH-1:0] pwm_use;
	logic [NCH-1:0] freq_evt;
	logic [7:0]     rd_mux;

	localparam logic [7:0] CPM_ADDR [3] = '{`CAC_ADDR_CPM0, `CAC_ADDR_CPM1, `CAC_ADDR_CPM2};
	localparam logic [7:0] CPL_ADDR [3] = '{`CAC_ADDR_CPL0, `CAC_ADDR_CPL1, `CAC_ADDR_CPL2};
	localparam logic [7:0] CPH_ADDR [3] = '{`CAC_ADDR_CPH0, `CAC_ADDR_CPH1, `CAC_ADDR_CPH2};

	assign run = ctl_run_r[`CAC_CTL_RUN];

	// clock dividers for the slow source rates
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || div_slow_r == 4'(DIV_SLOW - 1)) begin
			div_slow_r <= 4'h0;
		end else begin
			div_slow_r <= div_slow_r + 4'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst || div_fast_r == 2'(DIV_FAST - 1)) begin
			div_fast_r <= 2'h0;
		end else begin
			div_fast_r <= div_fast_r + 2'h1;
		end
	end

	always_comb begin
		case (cac_pkg::cac_clk_sel_t'(mode_r[`CAC_MD_CLKSEL_HI:`CAC_MD_CLKSEL_LO]))
			cac_pkg::CAC_CLK_DIV12:     src_tick = (div_slow_r == 4'(DIV_SLOW - 1));
			cac_pkg::CAC_CLK_DIV4:      src_tick = (div_fast_r == 2'(DIV_FAST - 1));
			cac_pkg::CAC_CLK_TIMER_OVF: src_tick = i_timer_ovf;
			cac_pkg::CAC_CLK_EXT_EDGE:  src_tick = i_ext_edge;
			cac_pkg::CAC_CLK_SYS:       src_tick = 1'b1;
			cac_pkg::CAC_CLK_EXT_OSC:   src_tick = i_ext_osc_tick;
			default:                    src_tick = 1'b0;
		endcase
	end

	assign tick = run && src_tick;

	// one length mask for every shared-length pwm channel
	assign pwm_mask = 11'((12'h100 << pwm_len_r) - 12'h1);

	assign clr_evt = clr_ctl_r[`CAC_CLR_POL] ? (i_cmp_result && !cmp_prev_r)
	                                         : (!i_cmp_result && cmp_prev_r);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			// follow the pins in reset, no false edge after release
			cmp_prev_r <= i_cmp_result;
			cap_prev_r <= i_capture_in;
		end else begin
			cmp_prev_r <= i_cmp_result;
			cap_prev_r <= i_capture_in;
		end
	end

	// per-channel event decode
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			cac_pkg::cac_mode_t md;
			logic               full_eq;
			logic               low_eq;
			assign md      = cac_decode(cpm_r[g]);
			assign full_eq = (cnt_r == {cph_r[g], cpl_r[g]});
			assign low_eq  = (cnt_r[7:0] == cpl_r[g]);
			assign cap_evt[g] = (md == cac_pkg::CAC_MODE_CAPTURE) &&
			                    ((cpm_r[g][`CAC_CPM_CAPP] && i_capture_in[g] && !cap_prev_r[g]) ||
			                     (cpm_r[g][`CAC_CPM_CAPN] && !i_capture_in[g] && cap_prev_r[g]));
			assign freq_evt[g] = tick && (md == cac_pkg::CAC_MODE_FREQ_OUT) && low_eq;
			// toggles need compare enable (held in decode)
			assign tog_evt[g] = freq_evt[g] ||
			                    (tick && (md == cac_pkg::CAC_MODE_HS_OUT) && full_eq);
			assign ch_evt[g] = cap_evt[g] ||
			                   (tick && cpm_r[g][`CAC_CPM_MAT] && cpm_r[g][`CAC_CPM_ECOM] &&
			                    full_eq && (md == cac_pkg::CAC_MODE_HS_OUT ||
			                                md == cac_pkg::CAC_MODE_SW_TIMER ||
			                                md == cac_pkg::CAC_MODE_FREQ_OUT));
			assign pwm_use[g] = (md == cac_pkg::CAC_MODE_PWM_SHARED) ||
			                    (md == cac_pkg::CAC_MODE_PWM16);
			assign pwm_lvl[g] = (md == cac_pkg::CAC_MODE_PWM16) ?
			                    (cnt_r >= {cph_r[g], cpl_r[g]}) :
			                    ((cnt_r[10:0] & pwm_mask) >= ({cph_r[g][2:0], cpl_r[g]} & pwm_mask));
		end
	endgenerate

	// shared counter, writable over the bus
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt_r <= 16'h0000;
		end else if (cac_hit(i_sfr_addr, `CAC_ADDR_CNT_LO)) begin
			cnt_r[7:0] <= i_sfr_wdata;
		end else if (cac_hit(i_sfr_addr, `CAC_ADDR_CNT_HI)) begin
			cnt_r[15:8] <= i_sfr_wdata;
		end else if (tick) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// control register: run bit and flags
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ctl_run_r <= `CAC_RST_BYTE;
			ovf_flag_r <= 1'b0;
			ch_flag_r <= '0;
		end else begin
			if (cac_hit(i_sfr_addr, `CAC_ADDR_CTL)) begin
				ctl_run_r <= i_sfr_wdata & 8'h40;
			end
			// wrap sets overflow flag, set beats clear
			// flags leave only by software write
			if (tick && cnt_r == 16'hffff) begin
				ovf_flag_r <= 1'b1;
			end else if (cac_hit(i_sfr_addr, `CAC_ADDR_CTL)) begin
				ovf_flag_r <= i_sfr_wdata[`CAC_CTL_OVF];
			end
			for (int i = 0; i < NCH; i++) begin
				if (ch_evt[i]) begin
					ch_flag_r[i] <= 1'b1;
				end else if (cac_hit(i_sfr_addr, `CAC_ADDR_CTL)) begin
					ch_flag_r[i] <= i_sfr_wdata[i];
				end
			end
		end
	end

	// configuration registers
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			clr_ctl_r <= `CAC_RST_BYTE;
			mode_r    <= `CAC_RST_BYTE;
			pwm_len_r <= 2'h0;
		end else begin
			if (cac_hit(i_sfr_addr, `CAC_ADDR_CLR_CTL)) begin
				clr_ctl_r <= i_sfr_wdata;
			end
			if (cac_hit(i_sfr_addr, `CAC_ADDR_MODE)) begin
				mode_r <= i_sfr_wdata;
			end
			if (cac_hit(i_sfr_addr, `CAC_ADDR_PWM_CFG)) begin
				pwm_len_r <= i_sfr_wdata[1:0];
			end
		end
	end

	// channel mode and compare registers
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			for (int i = 0; i < NCH; i++) begin
				cpm_r[i] <= `CAC_RST_BYTE;
				cpl_r[i] <= `CAC_RST_BYTE;
				cph_r[i] <= `CAC_RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (cac_hit(i_sfr_addr, CPM_ADDR[i])) begin
					cpm_r[i] <= i_sfr_wdata;
				end
				// low byte write clears compare enable
				if (cac_hit(i_sfr_addr, CPL_ADDR[i])) begin
					cpl_r[i] <= i_sfr_wdata;
					cpm_r[i][`CAC_CPM_ECOM] <= 1'b0;
				end else if (cap_evt[i]) begin
					cpl_r[i] <= cnt_r[7:0];
				end else if (freq_evt[i]) begin
					// zero high byte wraps to 256
					cpl_r[i] <= cpl_r[i] + cph_r[i];
				end
				// high byte write sets compare enable
				if (cac_hit(i_sfr_addr, CPH_ADDR[i])) begin
					cph_r[i] <= i_sfr_wdata;
					cpm_r[i][`CAC_CPM_ECOM] <= 1'b1;
				end else if (cap_evt[i]) begin
					cph_r[i] <= cnt_r[15:8];
				end
			end
		end
	end

	// channel output pins
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_channel_output_pin <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (clr_evt && clr_ctl_r[i]) begin
					o_channel_output_pin[i] <= 1'b0;
				end else if (tog_evt[i]) begin
					o_channel_output_pin[i] <= !o_channel_output_pin[i];
				end else if (pwm_use[i]) begin
					o_channel_output_pin[i] <= pwm_lvl[i];
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= (ovf_flag_r && mode_r[`CAC_MD_OVF_IE]) ||
			         (ch_flag_r[0] && cpm_r[0][`CAC_CPM_ECCF]) ||
			         (ch_flag_r[1] && cpm_r[1][`CAC_CPM_ECCF]) ||
			         (ch_flag_r[2] && cpm_r[2][`CAC_CPM_ECCF]);
		end
	end

	// read multiplexer
	always_comb begin
		rd_mux = 8'h00;
		case (i_sfr_addr)
			`CAC_ADDR_CTL:     rd_mux = {ovf_flag_r, ctl_run_r[6], 3'h0, ch_flag_r};
			`CAC_ADDR_CLR_CTL: rd_mux = clr_ctl_r;
			`CAC_ADDR_MODE:    rd_mux = mode_r;
			`CAC_ADDR_PWM_CFG: rd_mux = {6'h00, pwm_len_r};
			`CAC_ADDR_CNT_LO:  rd_mux = cnt_r[7:0];
			`CAC_ADDR_CNT_HI:  rd_mux = cnt_r[15:8];
			`CAC_ADDR_CPM0:    rd_mux = cpm_r[0];
			`CAC_ADDR_CPL0:    rd_mux = cpl_r[0];
			`CAC_ADDR_CPH0:    rd_mux = cph_r[0];
			`CAC_ADDR_CPM1:    rd_mux = cpm_r[1];
			`CAC_ADDR_CPL1:    rd_mux = cpl_r[1];
			`CAC_ADDR_CPH1:    rd_mux = cph_r[1];
			`CAC_ADDR_CPM2:    rd_mux = cpm_r[2];
			`CAC_ADDR_CPL2:    rd_mux = cpl_r[2];
			`CAC_ADDR_CPH2:    rd_mux = cph_r[2];
			default:           rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_sfr_rdata <= 8'h00;
		end else begin
			o_sfr_rdata <= rd_mux;
		end
	end

endmodule : cac_counter_array

`default_nettype wire

// *** verif/cac_props.sv ***
// port-level assertions of the counter array
`timescale 1ns/1ps
`default_nettype none
module cac_props #(
	parameter int NCH = 3
) (
	// clock and reset
	input wire logic           i_ref_clk,
	input wire logic           i_rst,
	// sfr bus
	input wire logic [7:0]     i_sfr_addr,
	input wire logic           i_sfr_wr,
	input wire logic [7:0]     i_sfr_wdata,
	input wire logic [7:0]     o_sfr_rdata,
	// pins
	input wire logic           i_cmp_result,
	input wire logic [NCH-1:0] o_channel_output_pin,
	input wire logic           o_irq
);
	logic [7:0] clr_r;
	logic       run_r;
	logic [3:0] ie_r;
	logic       cmp_q_r;
	logic [2:0] quiet_r;
	logic       ie_any;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	assign ie_any = |ie_r;
	// copies of bits only software changes
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			clr_r <= 8'h00;
			run_r <= 1'b0;
		end else if (i_sfr_wr && i_sfr_addr == 8'hce) begin
			clr_r <= i_sfr_wdata;
		end else if (i_sfr_wr && i_sfr_addr == 8'hd8) begin
			run_r <= i_sfr_wdata[6];
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ie_r <= 4'h0;
		end else if (i_sfr_wr && i_sfr_addr >= 8'hd9 && i_sfr_addr <= 8'hdc) begin
			ie_r[i_sfr_addr[1:0] - 2'h1] <= i_sfr_wdata[0];
		end
	end
	// cycles since the last write or comparator change
	always_ff @(posedge i_ref_clk) begin
		cmp_q_r <= i_cmp_result;
		if (i_rst || i_sfr_wr || i_cmp_result != cmp_q_r) begin
			quiet_r <= 3'h0;
		end else if (quiet_r != 3'h7) begin
			quiet_r <= quiet_r + 3'h1;
		end
	end
	a_unused_zero: assert property (
		$past(i_sfr_addr) == 8'hd8 |-> o_sfr_rdata[5:3] == 3'h0)
		else $error("control bits 5:3 not zero");
	a_unmapped_zero: assert property (
		$past(i_sfr_addr) == 8'h00 |-> o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_clr_readback: assert property (
		$past(i_sfr_addr) == 8'hce && !$past(i_sfr_wr) |-> o_sfr_rdata == clr_r)
		else $error("clear control readback wrong");
	a_run_readback: assert property (
		$past(i_sfr_addr) == 8'hd8 && !$past(i_sfr_wr) |-> o_sfr_rdata[6] == run_r)
		else $error("run bit readback wrong");
	a_cmp_clear: assert property (
		((clr_r[7] && $rose(i_cmp_result)) || (!clr_r[7] && $fell(i_cmp_result)))
		|-> ##[1:2] (o_channel_output_pin & clr_r[NCH-1:0]) == '0)
		else $error("enabled channel not cleared by comparator");
	a_pins_idle: assert property (
		quiet_r >= 3'h4 && !run_r |-> $stable(o_channel_output_pin))
		else $error("pin moved with counter stopped");
	a_irq_needs_ie: assert property (
		!ie_any && !$past(ie_any) && !$past(ie_any, 2) |-> !o_irq)
		else $error("interrupt with no enable");
	a_irq_holds: assert property (
		$fell(o_irq) |-> $past(i_sfr_wr) || $past(i_sfr_wr, 2) || $past(i_rst))
		else $error("interrupt dropped without software");
endmodule : cac_props

bind cac_counter_array cac_props #(.NCH(NCH)) i_cac_props (
	.i_ref_clk(i_ref_clk),
	.i_rst(i_rst),
	.i_sfr_addr(i_sfr_addr),
	.i_sfr_wr(i_sfr_wr),
	.i_sfr_wdata(i_sfr_wdata),
	.o_sfr_rdata(o_sfr_rdata),
	.i_cmp_result(i_cmp_result),
	.o_channel_output_pin(o_channel_output_pin),
	.o_irq(o_irq)
);
`default_nettype wire

// *** verif/cac_pin_partner.sv ***
// pin-side partner: comparator, capture pins and timer overflow source
`timescale 1ns/1ps
`default_nettype none
module cac_pin_partner (
	// clock
	input  wire logic       i_ref_clk,
	// comparator level the bench asks for
	input  wire logic       i_cmp_req,
	// levels seen by the counter array
	output var  logic       o_cmp_result,
	output var  logic [2:0] o_capture_in,
	output var  logic       o_timer_ovf
);
	logic [1:0] div_r;
	initial begin
		o_cmp_result = 1'b1;
		o_timer_ovf = 1'b0;
		div_r = 2'h0;
	end
	// capture pins rest at their pull-down level
	assign o_capture_in = 3'h0;
	// comparator settles one edge after the request
	always @(posedge i_ref_clk) begin
		o_cmp_result <= i_cmp_req;
		div_r <= div_r + 2'h1;
		o_timer_ovf <= (div_r == 2'h3);
	end
endmodule : cac_pin_partner
`default_nettype wire

// *** verif/test_counter_array_compare_outputs.sv ***
// self-checking bench of the counter array
`timescale 1ns/1ps
`default_nettype none
module test_counter_array_compare_outputs;
	logic       ref_clk = 1'b0;
	logic       rst;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       tovf;
	logic [2:0] cap;
	logic       cmp;
	logic       cmp_req;
	logic [2:0] pins;
	logic       irq;
	int         err_count = 0;
	int         comparisons = 0;
	always #4 ref_clk = ~ref_clk;
	cac_counter_array i_cac_counter_array (
		.i_ref_clk(ref_clk),
		.i_rst(rst),
		.i_sfr_addr(sfr_addr),
		.i_sfr_wr(sfr_wr),
		.i_sfr_wdata(sfr_wdata),
		.o_sfr_rdata(sfr_rdata),
		.i_timer_ovf(tovf),
		.i_ext_edge(1'b0),
		.i_ext_osc_tick(1'b0),
		.i_capture_in(cap),
		.i_cmp_result(cmp),
		.o_channel_output_pin(pins),
		.o_irq(irq)
	);
	cac_pin_partner i_cac_pin_partner (
		.i_ref_clk(ref_clk),
		.i_cmp_req(cmp_req),
		.o_cmp_result(cmp),
		.o_capture_in(cap),
		.o_timer_ovf(tovf)
	);
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr <= a;
		@(posedge ref_clk);
		@(posedge ref_clk);
		check($sformatf("reg %h", a), {8'h00, sfr_rdata}, {8'h00, exp});
	endtask : rd
	task automatic wait_pin(input int n, input logic v);
		int k;
		k = 0;
		while (pins[n] !== v && k < 400) begin
			@(posedge ref_clk);
			k++;
		end
		check($sformatf("pin %0d", n), {15'h0, pins[n]}, {15'h0, v});
		if (k == 400) begin
			give_verdict();
		end
	endtask : wait_pin
	task automatic irq_is(input logic v);
		repeat (3) @(posedge ref_clk);
		check("irq", {15'h0, irq}, {15'h0, v});
	endtask : irq_is
	task automatic test_regs();
		rd(8'hce, 8'h00);
		rd(8'hd8, 8'h00);
		wr(8'hd8, 8'h38);
		rd(8'hd8, 8'h00);
		wr(8'hce, 8'hff);
		rd(8'hce, 8'hff);
		wr(8'hce, 8'h00);
		wr(8'h00, 8'h55);
		rd(8'h00, 8'h00);
		$display("test_regs done");
	endtask : test_regs
	task automatic test_hs();
		wr(8'hd9, 8'h08);
		wr(8'hda, 8'h4c);
		wr(8'hfb, 8'h10);
		rd(8'hda, 8'h0c);
		wr(8'hfc, 8'h00);
		rd(8'hda, 8'h4c);
		wr(8'hd8, 8'h40);
		wait_pin(0, 1'b1);
		rd(8'hd8, 8'h41);
		irq_is(1'b0);
		wr(8'hda, 8'h4d);
		irq_is(1'b1);
		rd(8'hd8, 8'h41);
		wr(8'hd8, 8'h40);
		irq_is(1'b0);
		$display("test_hs done");
	endtask : test_hs
	task automatic test_skip();
		wr(8'hd8, 8'h00);
		wr(8'hf9, 8'hf8);
		wr(8'hfa, 8'hff);
		wr(8'hda, 8'h0c);
		wr(8'hfb, 8'h02);
		wr(8'hd9, 8'h09);
		wr(8'hd8, 8'h40);
		repeat (30) @(posedge ref_clk);
		check("pin 0 held", {15'h0, pins[0]}, 16'h0001);
		rd(8'hd8, 8'hc0);
		irq_is(1'b1);
		wr(8'hd8, 8'h40);
		irq_is(1'b0);
		$display("test_skip done");
	endtask : test_skip
	task automatic test_freq();
		logic [7:0] hb [2] = '{8'h04, 8'h00};
		logic p;
		int k;
		wr(8'hd9, 8'h08);
		wr(8'hdb, 8'h46);
		wr(8'he9, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wr(8'hea, hb[i]);
			p = pins[1];
			wait_pin(1, ~p);
			wait_pin(1, p);
			k = 0;
			while (pins[1] === p && k < 400) begin
				@(posedge ref_clk);
				k++;
			end
			check("freq period", k[15:0], (hb[i] == 8'h00) ? 16'h0100 : {8'h00, hb[i]});
		end
		rd(8'hd8, 8'h40);
		$display("test_freq done");
	endtask : test_freq
	task automatic test_clear();
		wait_pin(1, 1'b1);
		wr(8'hd8, 8'h00);
		wr(8'hce, 8'h01);
		cmp_req <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("pin 0 cleared", {13'h0, pins}, 16'h0002);
		wr(8'hce, 8'h82);
		cmp_req <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("pin 1 cleared", {13'h0, pins}, 16'h0000);
		$display("test_clear done");
	endtask : test_clear
	task automatic test_pwm();
		wr(8'heb, 8'h80);
		wr(8'hec, 8'h00);
		wr(8'hdc, 8'h42);
		wr(8'hdf, 8'h00);
		wr(8'hf9, 8'h10);
		wr(8'hfa, 8'h01);
		@(posedge ref_clk);
		check("pwm 8 bit", {13'h0, pins}, 16'h0000);
		wr(8'hdf, 8'h01);
		@(posedge ref_clk);
		check("pwm 9 bit", {13'h0, pins}, 16'h0004);
		$display("test_pwm done");
	endtask : test_pwm
	task automatic test_clock();
		wr(8'hd9, 8'h04);
		wr(8'hf9, 8'h00);
		wr(8'hfa, 8'h00);
		wr(8'hd8, 8'h40);
		repeat (38) @(posedge ref_clk);
		wr(8'hd8, 8'h00);
		rd(8'hf9, 8'h0a);
		rd(8'hfa, 8'h00);
		$display("test_clock done");
	endtask : test_clock
	initial begin
		rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		cmp_req = 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		test_regs();
		test_hs();
		test_skip();
		test_freq();
		test_clear();
		test_pwm();
		test_clock();
		give_verdict();
	end
	initial begin
		repeat (50000) @(posedge ref_clk);
		err_count++;
		$display("FAIL run time expected end seen none");
		give_verdict();
	end
endmodule : test_counter_array_compare_outputs
`default_nettype wire
